// ==== dv/acc_adc_model.sv ====
// Behavioural input mux and comparator facing the conversion block.
// Assumes dac_trial and sample_hold come from the block on pclk.
`timescale 1ns/1ps
`default_nettype none
module acc_adc_model
    import acc_pkg::*;
(
    // Clock.
    input  wire logic       pclk,
    // Converter side.
    input  wire logic [4:0] mux_channel,
    input  wire logic       conv_power_down,
    input  wire logic       sample_hold,
    input  wire logic [7:0] dac_trial,
    input  wire logic [7:0] bias,
    output logic            comp_high
);
    logic [7:0] level;
    logic [7:0] held_q;
    logic       junk_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Reserved codes carry a nonzero level, so a forced zero result shows.
    always_comb begin
        if (mux_channel <= ACC_CHAN_EXT_LAST) begin
            level = 8'h13 + 8'h29 * {3'h0, mux_channel};
        end else if (mux_channel == ACC_CHAN_REF_HIGH) begin
            level = 8'hff;
        end else if (mux_channel == ACC_CHAN_REF_LOW) begin
            level = 8'h00;
        end else begin
            level = 8'h5a;
        end
    end

    always @(posedge pclk) begin
        junk_q <= ~junk_q;
        if (sample_hold) begin
            held_q <= level ^ bias;
        end
    end

    // A powered-down converter gives no stable answer.
    assign comp_high = conv_power_down ? junk_q : (held_q >= dac_trial);
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the conversion control block over APB.
// Assumes the converter model returns the held level as the result.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import acc_pkg::*;
    localparam int TIMEOUT = 20000;
    logic        pclk, presetn, psel, penable, pwrite, er, sh_q;
    logic        osc_clk_tick, stop_mode, comp_high, pready, pslverr;
    logic        cpu_irq, dma_req, conv_power_down, sample_hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [4:0]  mux_channel;
    logic [7:0]  dac_trial, bias;
    logic [4:0]  chans [5] = '{5'h00, 5'h05, 5'h1d, 5'h1e, 5'h07};
    int          cyc, rises, last_rise, prev_rise, i, t, n;
    int          mismatches, total_checks;

    acc_conv_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_clk_tick(osc_clk_tick), .stop_mode(stop_mode),
        .cpu_irq(cpu_irq), .dma_req(dma_req), .mux_channel(mux_channel),
        .conv_power_down(conv_power_down), .sample_hold(sample_hold),
        .dac_trial(dac_trial), .comp_high(comp_high));
    acc_adc_model u_adc (.pclk(pclk), .mux_channel(mux_channel),
        .conv_power_down(conv_power_down), .sample_hold(sample_hold),
        .dac_trial(dac_trial), .bias(bias), .comp_high(comp_high));

    ////////////////////////////////////////////////////////////////////////
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // Sample phases mark conversion starts, so their spacing gives the period.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        sh_q <= sample_hold;
        osc_clk_tick <= (cyc % 3 == 0);
        if (sample_hold === 1'b1 && sh_q === 1'b0) begin
            rises <= rises + 1;
            prev_rise <= last_rise;
            last_rise <= cyc;
        end
        if (cyc == TIMEOUT) begin
            mismatches++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("Error at %0t: got %h not in %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        @(negedge pclk);
    endtask

    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(r, {24'h0, e});
    endtask

    task automatic wait_rises(input int cnt);
        int goal;
        goal = rises + cnt;
        for (int k = 0; k < 2000 && rises < goal; k++)
            @(posedge pclk);
    endtask

    task automatic wait_done();
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, ACC_OFS_STATUS_CTRL, 8'h00);
            if (r[7] === 1'b1) break;
        end
    endtask

    function automatic logic [7:0] exp_res(input logic [4:0] ch);
        if (ch <= ACC_CHAN_EXT_LAST) return (8'h13 + 8'h29 * {3'h0, ch}) ^ bias;
        if (ch == ACC_CHAN_REF_HIGH) return 8'hff ^ bias;
        if (ch == ACC_CHAN_REF_LOW) return bias;
        return 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, stop_mode, presetn} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        bias = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rc(ACC_OFS_STATUS_CTRL, 8'h1f);
        rc(ACC_OFS_RESULT, 8'h00);
        rc(ACC_OFS_CLOCK_SEL, 8'h00);
        chk(conv_power_down, 1'b1);
        wr(ACC_OFS_RESULT, 8'hff);
        rc(ACC_OFS_RESULT, 8'h00);
        rc(12'h048, 8'h00);
        chk(er, 1'b1);
        wr(ACC_OFS_CLOCK_SEL, 8'h10);
        rc(ACC_OFS_CLOCK_SEL, 8'h10);
        wr(ACC_OFS_STATUS_CTRL, 8'h00);
        wait_done();
        foreach (chans[j]) begin
            wr(ACC_OFS_STATUS_CTRL, {3'h0, chans[j]});
            n = rises;
            chk(mux_channel, chans[j]);
            chk(conv_power_down, 1'b0);
            wait_done();
            rc(ACC_OFS_RESULT, exp_res(chans[j]));
            rc(ACC_OFS_STATUS_CTRL, {3'h0, chans[j]});
            repeat (40) @(posedge pclk);
            chk_rng(rises, n + 1, n + 1);
        end
        n = rises;
        repeat (60) @(posedge pclk);
        chk_rng(rises, n, n);
        for (int c = 0; c < 8; c++) begin
            t = (c > 3) ? 16 : (1 << c);
            wr(ACC_OFS_CLOCK_SEL, {c[2:0], 5'h10});
            wr(ACC_OFS_STATUS_CTRL, 8'h22);
            wait_rises(2);
            chk_rng(last_rise - prev_rise, 16 * t, 17 * t + 4);
        end
        wr(ACC_OFS_CLOCK_SEL, 8'h00);
        wr(ACC_OFS_STATUS_CTRL, 8'h22);
        wait_rises(2);
        chk_rng(last_rise - prev_rise, 48, 55);
        bias <= 8'h11;
        wait_rises(3);
        rc(ACC_OFS_STATUS_CTRL, 8'ha2);
        rc(ACC_OFS_RESULT, exp_res(5'h02));
        bias <= 8'h00;
        wr(ACC_OFS_CLOCK_SEL, 8'h10);
        wr(ACC_OFS_STATUS_CTRL, 8'h41);
        for (i = 0; i < 200 && cpu_irq !== 1'b1; i++)
            @(posedge pclk);
        chk({cpu_irq, dma_req}, 2'b10);
        rc(ACC_OFS_STATUS_CTRL, 8'h41);
        rc(ACC_OFS_RESULT, exp_res(5'h01));
        @(negedge pclk);
        chk(cpu_irq, 1'b0);
        wr(ACC_OFS_STATUS_CTRL, 8'hc1);
        rc(ACC_OFS_STATUS_CTRL, 8'hc1);
        for (i = 0; i < 200 && dma_req !== 1'b1; i++)
            @(posedge pclk);
        chk({cpu_irq, dma_req}, 2'b01);
        wr(ACC_OFS_STATUS_CTRL, 8'h01);
        chk({cpu_irq, dma_req}, 2'b00);
        wr(ACC_OFS_CLOCK_SEL, 8'hf0);
        wr(ACC_OFS_STATUS_CTRL, 8'h00);
        wait_rises(1);
        stop_mode <= 1'b1;
        n = rises;
        repeat (400) @(posedge pclk);
        rc(ACC_OFS_STATUS_CTRL, 8'h00);
        chk_rng(rises, n, n);
        stop_mode <= 1'b0;
        wait_done();
        rc(ACC_OFS_RESULT, exp_res(5'h00));
        wr(ACC_OFS_STATUS_CTRL, 8'h1f);
        n = rises;
        repeat (300) @(posedge pclk);
        chk_rng(rises, n, n);
        chk(conv_power_down, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== verilog/acc_conv_ctrl.sv ====
// Register bank, clock prescaler and run control of the conversion block.
// Assumes an APB master on pclk; analog mux, comparator and DAC are outside.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl
    import acc_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // System.
    input  wire logic        osc_clk_tick,
    input  wire logic        stop_mode,
    // Service requests.
    output logic             cpu_irq,
    output logic             dma_req,
    // Analog converter.
    output logic [4:0]       mux_channel,
    output logic             conv_power_down,
    output logic             sample_hold,
    output logic [7:0]       dac_trial,
    input  wire logic        comp_high
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers.
    function automatic logic is_reserved(input logic [4:0] ch);
        is_reserved = (ch > ACC_CHAN_EXT_LAST) && (ch < ACC_CHAN_REF_HIGH);
    endfunction

    function automatic logic [3:0] presc_last(input logic [2:0] code);
        // Terminal count of the divider, one less than the ratio.
        case (code)
            3'h0:    presc_last = 4'h0;
            3'h1:    presc_last = 4'h1;
            3'h2:    presc_last = 4'h3;
            3'h3:    presc_last = 4'h7;
            default: presc_last = 4'hf;
        endcase
    endfunction

    acc_seq_if sq ();

    acc_sar_seq u_seq (
        .pclk        (pclk),
        .presetn     (presetn),
        .sq          (sq.seq),
        .comp_high   (comp_high),
        .sample_hold (sample_hold),
        .dac_trial   (dac_trial)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode. Zero wait states, so every access completes at once.
    logic access;
    logic hit_ctrl;
    logic hit_res;
    logic hit_clk;
    logic ctrl_wr;
    logic clk_wr;
    logic res_rd;

    assign access   = psel && penable;
    assign hit_ctrl = (paddr == ACC_OFS_STATUS_CTRL);
    assign hit_res  = (paddr == ACC_OFS_RESULT);
    assign hit_clk  = (paddr == ACC_OFS_CLOCK_SEL);
    assign ctrl_wr  = access && pwrite && hit_ctrl && pstrb[0];
    assign clk_wr   = access && pwrite && hit_clk && pstrb[0];
    assign res_rd   = access && !pwrite && hit_res;
    assign pready   = 1'b1;
    assign pslverr  = access && !(hit_ctrl || hit_res || hit_clk);

    ////////////////////////////////////////////////////////////////////////
    // Status/control and clock select registers.
    logic       done_sel_q, done_sel_d;
    logic       irq_en_q, irq_en_d;
    logic       cont_q, cont_d;
    logic [4:0] chan_q, chan_d;
    logic [2:0] presc_q, presc_d;
    logic       src_q, src_d;
    logic       first_q, first_d;
    logic       pend_q, pend_d;
    logic       run_q, run_d;
    logic [7:0] result_q, result_d;
    logic       conv_end;
    logic       set_done;

    assign conv_end = sq.done;
    // In continuous mode the flag marks only the first result after a write.
    assign set_done = conv_end && !irq_en_q && (!cont_q || !first_q);

    always_comb begin
        done_sel_d = done_sel_q;
        irq_en_d   = irq_en_q;
        cont_d     = cont_q;
        chan_d     = chan_q;
        presc_d    = presc_q;
        src_d      = src_q;
        first_d    = first_q;
        pend_d     = pend_q;
        run_d      = run_q;
        result_d   = result_q;
        if (ctrl_wr) begin
            irq_en_d = pwdata[ACC_BIT_IRQ_EN];
            cont_d   = pwdata[ACC_BIT_CONT];
            chan_d   = pwdata[ACC_CHAN_MSB:0];
            first_d  = 1'b0;
            // Power-off code leaves nothing to run.
            run_d    = (pwdata[ACC_CHAN_MSB:0] != ACC_CHAN_OFF);
            if (pwdata[ACC_BIT_IRQ_EN]) begin
                done_sel_d = pwdata[ACC_BIT_DONE_SEL];
            end else begin
                done_sel_d = set_done;
            end
        end else begin
            if (set_done) begin
                done_sel_d = 1'b1;
            end else if (res_rd && !irq_en_q) begin
                done_sel_d = 1'b0;
            end
            if (conv_end && !cont_q) begin
                run_d = 1'b0;
            end
        end
        if (conv_end) begin
            first_d = 1'b1;
            // Reserved inputs give a defined zero; new data always wins.
            result_d = is_reserved(chan_q) ? 8'h00 : sq.result;
        end
        // A completion in the clearing cycle keeps the request.
        if (conv_end && irq_en_q) begin
            pend_d = 1'b1;
        end else if (ctrl_wr || res_rd) begin
            pend_d = 1'b0;
        end
        if (clk_wr) begin
            presc_d = pwdata[ACC_PRESC_MSB:ACC_PRESC_LSB];
            src_d   = pwdata[ACC_BIT_SRC];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_sel_q <= ACC_RST_STATUS_CTRL[ACC_BIT_DONE_SEL];
            irq_en_q   <= ACC_RST_STATUS_CTRL[ACC_BIT_IRQ_EN];
            cont_q     <= ACC_RST_STATUS_CTRL[ACC_BIT_CONT];
            chan_q     <= ACC_RST_STATUS_CTRL[ACC_CHAN_MSB:0];
            presc_q    <= ACC_RST_PRESCALE;
            src_q      <= ACC_RST_SRC;
            first_q    <= 1'b0;
            pend_q     <= 1'b0;
            run_q      <= 1'b0;
            result_q   <= ACC_RST_RESULT;
        end else begin
            done_sel_q <= done_sel_d;
            irq_en_q   <= irq_en_d;
            cont_q     <= cont_d;
            chan_q     <= chan_d;
            presc_q    <= presc_d;
            src_q      <= src_d;
            first_q    <= first_d;
            pend_q     <= pend_d;
            run_q      <= run_d;
            result_q   <= result_d;
        end
    end

    // A set select steers the request from cpu_irq to dma_req.
    assign cpu_irq = pend_q && irq_en_q && !done_sel_q;
    assign dma_req = pend_q && irq_en_q && done_sel_q;
    assign mux_channel     = chan_q;
    assign conv_power_down = (chan_q == ACC_CHAN_OFF);

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock: the selected source divided by the prescaler.
    logic [3:0] div_q, div_d;
    logic       tick_q, tick_d;
    logic       src_tick;

    assign src_tick = src_q ? 1'b1 : osc_clk_tick;

    always_comb begin
        div_d  = div_q;
        tick_d = 1'b0;
        if (src_tick) begin
            if (div_q >= presc_last(presc_q)) begin
                div_d  = 4'h0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run control. A write aborts any conversion in flight, so a result started after it
    // belongs to the channel last written; one completing in the write cycle itself does not.
    assign sq.tick  = tick_q;
    assign sq.abort = ctrl_wr || stop_mode || conv_power_down;
    // The completing cycle of a single conversion must not launch another.
    assign sq.start = run_q && !sq.busy && !sq.abort
                      && (cont_q || !conv_end);

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle.
    logic [31:0] prdata_q, prdata_d;

    always_comb begin
        prdata_d = prdata_q;
        if (psel && !penable && !pwrite) begin
            prdata_d = 32'h0000_0000;
            if (paddr == ACC_OFS_STATUS_CTRL) begin
                prdata_d[7:0] = {done_sel_q, irq_en_q, cont_q, chan_q};
            end else if (paddr == ACC_OFS_RESULT) begin
                prdata_d[7:0] = result_q;
            end else if (paddr == ACC_OFS_CLOCK_SEL) begin
                prdata_d[7:0] = {presc_q, src_q, 4'h0};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_done_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        (res_rd && !irq_en_q && !conv_end && !ctrl_wr) |=> !done_sel_q)
        else $error("done flag survived a result read");

    a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && irq_en_q && !ctrl_wr) |=> (cpu_irq || dma_req))
        else $error("conversion end raised no request");

    a_irq_dropped: assert property (@(posedge pclk) disable iff (!presetn)
        ((ctrl_wr || res_rd) && !conv_end) |=> !cpu_irq && !dma_req)
        else $error("request not dropped after clearing access");

    a_result_loaded: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && !is_reserved(chan_q))
        |=> result_q == $past(sq.result))
        else $error("result register missed a conversion");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && is_reserved(chan_q)) |=> result_q == 8'h00)
        else $error("reserved channel gave a non-zero result");

    a_off_no_start: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_power_down || stop_mode) |-> !sq.start)
        else $error("conversion started while powered down or stopped");

    a_cont_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && cont_q && !sq.abort)
        |=> sq.busy)
        else $error("continuous mode did not restart");

    a_single_stops: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && !cont_q && !ctrl_wr) |=> !run_q ##1 !sq.busy)
        else $error("single mode ran a second conversion");

    a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && !irq_en_q && !cont_q && !ctrl_wr)
        |=> done_sel_q)
        else $error("single conversion end left the done flag clear");

    a_sel_written: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && pwdata[ACC_BIT_IRQ_EN])
        |=> done_sel_q == $past(pwdata[ACC_BIT_DONE_SEL]))
        else $error("service select did not take the written value");

    // Cycles since the last conversion tick, and whether the divider has
    // run on the bus clock at a ratio of sixteen, untouched, since then.
    logic [3:0] gap_q, gap_d;
    logic       steady_q, steady_d;

    always_comb begin
        gap_d    = tick_q ? 4'h0 : gap_q + 4'h1;
        steady_d = tick_q ? (src_q && presc_q[2]) : steady_q;
        // Any clock select write restarts the watch, even to the same ratio.
        if (clk_wr) begin
            steady_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q    <= 4'h0;
            steady_q <= 1'b0;
        end else begin
            gap_q    <= gap_d;
            steady_q <= steady_d;
        end
    end

    a_div16_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_q && steady_q) |-> gap_q == 4'hf)
        else $error("divide by sixteen ticked off its period");

endmodule
`default_nettype wire

// ==== verilog/acc_pkg.sv ====
// Constants, register map and field layout of the conversion control block.
// Assumes a 32-bit APB register bus and an 8-bit successive approximation
// converter whose comparator and trial DAC sit outside this logic.
package acc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [11:0] ACC_OFS_STATUS_CTRL = 12'h03c;
    localparam logic [11:0] ACC_OFS_RESULT      = 12'h040;
    localparam logic [11:0] ACC_OFS_CLOCK_SEL   = 12'h044;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the status/control and clock select registers.
    localparam int ACC_BIT_DONE_SEL = 7;
    localparam int ACC_BIT_IRQ_EN   = 6;
    localparam int ACC_BIT_CONT     = 5;
    localparam int ACC_CHAN_MSB     = 4;
    localparam int ACC_PRESC_MSB    = 7;
    localparam int ACC_PRESC_LSB    = 5;
    localparam int ACC_BIT_SRC      = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] ACC_RST_STATUS_CTRL = 8'h1f;
    localparam logic [7:0] ACC_RST_RESULT      = 8'h00;
    localparam logic [2:0] ACC_RST_PRESCALE    = 3'h0;
    localparam logic       ACC_RST_SRC         = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Channel codes.
    localparam logic [4:0] ACC_CHAN_EXT_LAST = 5'h05;
    localparam logic [4:0] ACC_CHAN_REF_HIGH = 5'h1d;
    localparam logic [4:0] ACC_CHAN_REF_LOW  = 5'h1e;
    localparam logic [4:0] ACC_CHAN_OFF      = 5'h1f;

    ////////////////////////////////////////////////////////////////////////
    // Conversion timing in conversion clock ticks; the total counts the sync tick too.
    localparam logic [3:0] ACC_SAMPLE_LAST = 4'h7;
    localparam logic [3:0] ACC_BIT_TOP     = 4'h7;
    localparam logic [4:0] ACC_CONV_TICKS  = 5'h11;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_SYNC,
        ACC_SAMPLE,
        ACC_CONVERT
    } acc_seq_state_e;

endpackage

// ==== verilog/acc_sar_seq.sv ====
// Successive approximation sequencer: sync, eight sample ticks, eight trials.
// Assumes comp_high is synchronous to pclk and settled by the next tick.
`timescale 1ns/1ps
`default_nettype none
module acc_sar_seq
    import acc_pkg::*;
(
    // Clock and reset.
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Control side.
    acc_seq_if.seq     sq,
    // Converter side.
    input  wire logic  comp_high,
    output logic       sample_hold,
    output logic [7:0] dac_trial
);

    acc_seq_state_e state_q, state_d;
    logic [3:0]     step_q, step_d;
    logic [7:0]     trial_q, trial_d;
    logic           done_q, done_d;
    logic [7:0]     kept;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        trial_d = trial_q;
        done_d  = 1'b0;
        kept    = trial_q;
        case (state_q)
            ACC_IDLE: begin
                if (sq.start) begin
                    state_d = ACC_SYNC;
                end
            end
            ACC_SYNC: begin
                if (sq.tick) begin
                    state_d = ACC_SAMPLE;
                    step_d  = 4'h0;
                end
            end
            ACC_SAMPLE: begin
                if (sq.tick) begin
                    step_d = step_q + 4'h1;
                    if (step_q == ACC_SAMPLE_LAST) begin
                        state_d = ACC_CONVERT;
                        step_d  = ACC_BIT_TOP;
                        trial_d = 8'h80;
                    end
                end
            end
            ACC_CONVERT: begin
                if (sq.tick) begin
                    // A low comparator drops the bit under trial.
                    if (!comp_high) begin
                        kept[step_q[2:0]] = 1'b0;
                    end
                    if (step_q == 4'h0) begin
                        trial_d = kept;
                        done_d  = 1'b1;
                        state_d = ACC_IDLE;
                    end else begin
                        trial_d = kept;
                        trial_d[step_q[2:0] - 3'h1] = 1'b1;
                        step_d  = step_q - 4'h1;
                    end
                end
            end
            default: state_d = ACC_IDLE;
        endcase
        // Abort wins over every step, including a completing one.
        if (sq.abort) begin
            state_d = ACC_IDLE;
            done_d  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ACC_IDLE;
            step_q  <= 4'h0;
            trial_q <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
            trial_q <= trial_d;
            done_q  <= done_d;
        end
    end

    assign sq.busy     = (state_q != ACC_IDLE);
    assign sq.done     = done_q;
    assign sq.result   = trial_q;
    assign sample_hold = (state_q == ACC_SAMPLE);
    assign dac_trial   = trial_q;

    ////////////////////////////////////////////////////////////////////////
    // Ticks seen since start; the sync tick plus sixteen make a conversion.
    logic [4:0] tick_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 5'h00;
        end else if (state_q == ACC_IDLE) begin
            tick_cnt_q <= 5'h00;
        end else if (sq.tick) begin
            tick_cnt_q <= tick_cnt_q + 5'h01;
        end
    end

    a_conv_tick_count: assert property (@(posedge pclk) disable iff (!presetn)
        done_d |-> (tick_cnt_q + 5'h01) == ACC_CONV_TICKS)
        else $error("conversion did not take seventeen ticks from start");

    a_abort_to_idle: assert property (@(posedge pclk) disable iff (!presetn)
        sq.abort |=> !sq.busy && !sq.done)
        else $error("abort did not return the sequencer to idle");

endmodule
`default_nettype wire

// ==== verilog/acc_seq_if.sv ====
// Handshake between the register bank and the conversion sequencer.
// Both ends run on pclk; tick is a one-cycle conversion clock enable.
`timescale 1ns/1ps
`default_nettype none
interface acc_seq_if;
    logic       start;
    logic       abort;
    logic       tick;
    logic       busy;
    logic       done;
    logic [7:0] result;

    modport ctrl (output start, output abort, output tick,
                  input busy, input done, input result);
    modport seq (input start, input abort, input tick,
                 output busy, output done, output result);
endinterface
`default_nettype wire
